// File: gpm_pkg.sv
package gpm_pkg;

  // number of multiplexed lines
  localparam int NLINES = 7;
  // width of one line's function selection field
  localparam int SEL_W = 3;
  // lines held in the first selection register, the rest in the second
  localparam int SEL_A_LINES = 4;
  localparam int SEL_A_W = SEL_A_LINES * SEL_W;
  localparam int SEL_B_W = (NLINES - SEL_A_LINES) * SEL_W;

  // function selection codes, primary first
  localparam logic [2:0] SEL_PRIMARY = 3'h0;
  localparam logic [2:0] SEL_ALT1 = 3'h1;
  localparam logic [2:0] SEL_ALT2 = 3'h2;
  localparam logic [2:0] SEL_ALT3 = 3'h3;
  localparam logic [2:0] SEL_ALT4 = 3'h4;

  // lines powered from the io supply domain (lines 2 and 4)
  localparam logic [6:0] IO_DOMAIN_LINES = 7'h14;

  // clock rate and debounce filter time
  localparam int CLK_HZ = 40_000_000;
  localparam int DEB_TIME_US = 100;
  localparam int DEB_CYCLES = DEB_TIME_US * (CLK_HZ / 1_000_000);
  localparam int DEB_CNT_W = 12;

  // reset value of every per-line register
  localparam logic [6:0] RST_LINES = 7'h00;

  // levels seen by the core from secondary input functions
  typedef struct packed {
    logic power_down_in;
    logic periph_power_req_a;
    logic periph_power_req_b;
    logic reset_in;
    logic warm_reset_in_n;
    logic bus_supply_sense_in;
    logic converter_sync_in;
    logic hold_on_in;
    logic sleep_req_in_n;
    logic dvs_data_in;
    logic dvs_clock_cs_in;
  } gpm_fin_s;

  // idle levels: all inactive, active-low ones high
  localparam gpm_fin_s FIN_IDLE = 11'h044;

  // core signals to be driven out by secondary output functions
  typedef struct packed {
    logic ext_supply_en_a;
    logic ext_supply_en_b;
    logic ext_supply_en_c;
    logic supplies_valid_out;
    logic dvs_data_out;
    logic dvs_data_oe;
    logic dvs_clock_cs_out;
    logic dvs_clock_cs_oe;
  } gpm_fout_s;

  // primary function configuration
  typedef struct packed {
    logic enable;
    logic [6:0] line_direction;
    logic [6:0] line_debounce_enable;
    logic [6:0] line_pull_config_a;
    logic [6:0] line_pull_config_b;
    logic [6:0] line_open_drain_enable;
    logic [6:0] rise_enable;
    logic [6:0] fall_enable;
    logic [6:0] irq_mask;
    logic [6:0] wake_enable;
  } gpm_pcfg_s;

  // secondary function pad configuration
  typedef struct packed {
    logic [6:0] pull_up;
    logic [6:0] pull_down;
    logic [6:0] open_drain;
  } gpm_scfg_s;

  // output data write, set and clear strobes
  typedef struct packed {
    logic write_en;
    logic [6:0] write_data;
    logic set_en;
    logic [6:0] set_bits;
    logic clear_en;
    logic [6:0] clear_bits;
  } gpm_dwr_s;

endpackage

// File: gpm_debounce.sv
`timescale 1ns/1ps
module gpm_debounce #(
  parameter int CYCLES = gpm_pkg::DEB_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic level_in,
  input wire logic enable,
  output logic level_out
);

  // filter state: run length of disagreement and accepted level
  typedef struct packed {
    logic [gpm_pkg::DEB_CNT_W-1:0] cnt;
    logic level;
  } gpm_deb_s;

  gpm_deb_s s;
  gpm_deb_s next_s;

  // accept a new level only after it has held for the whole filter time
  always_comb begin
    next_s = s;
    if (!enable) begin
      // filter bypassed: follow the input directly
      next_s.level = level_in;
      next_s.cnt = '0;
    end else if (level_in == s.level) begin
      // glitch ended, restart the run
      next_s.cnt = '0;
    end else if (s.cnt == gpm_pkg::DEB_CNT_W'(CYCLES - 1)) begin
      next_s.level = level_in;
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.level;

endmodule

// File: gpm_port.sv
// Behaviour
// - seven lines, each primary or secondary
// - line 0: power-down, request b, supply enable a
// - line 1: reset, warm reset, bus sense, request a
// - line 2: request b or dvs link data
// - line 3: supply enable a or converter sync
// - line 4: supply enable b or dvs clock/select
// - line 5: hold-on, supply enable c, sleep request
// - line 6: supplies valid or supply enable c
// - rising, falling or both edge interrupts, masked
// - interrupts only in primary function
// - every line can raise a wake-up
// - lines 2 and 4 never wake from off
// - supply enable outputs follow power-up sequencer
// - two selection registers choose line functions
// - per-line direction in primary mode
// - input data read, output data drives
// - per-line debounce enable
// - global enable for all primary lines
// - set and clear strobes change output bits
// - two pull registers choose pull-up or pull-down
// - per-line open-drain output
// - secondary lines use separate pull/drain settings
// - masked edges are neither recorded nor signalled on irq, but still raise a wake-up
`timescale 1ns/1ps
module gpm_port (
  input wire logic clk_sys,
  input wire logic srst,
  // pad side
  input wire logic [6:0] pad_in,
  output logic [6:0] pad_out,
  output logic [6:0] pad_oe,
  output logic [6:0] pad_pull_up,
  output logic [6:0] pad_pull_down,
  // function selection
  input wire logic [gpm_pkg::SEL_A_W-1:0] pad_func_select_a,
  input wire logic [gpm_pkg::SEL_B_W-1:0] pad_func_select_b,
  // configuration
  input wire gpm_pkg::gpm_pcfg_s pcfg,
  input wire gpm_pkg::gpm_scfg_s scfg,
  input wire gpm_pkg::gpm_dwr_s dwr,
  input wire logic [6:0] status_clear,
  input wire logic off_state,
  // core side of secondary functions
  input wire gpm_pkg::gpm_fout_s fout,
  output gpm_pkg::gpm_fin_s fin,
  // status
  output logic [6:0] data_in,
  output logic [6:0] out_data,
  output logic [6:0] edge_status,
  output logic irq,
  output logic wake_req
);

  // state of the port, except the debounce filters
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] stable;
    logic [6:0] prev;
    logic [6:0] out_data;
    logic [6:0] status;
    logic [6:0] data_in;
    logic [6:0] pad_out;
    logic [6:0] pad_oe;
    logic [6:0] pull_up;
    logic [6:0] pull_down;
    gpm_pkg::gpm_fin_s fin;
    logic irq;
    logic wake;
    // ones shift in after reset until the input pipeline holds real levels
    logic [5:0] settle;
  } gpm_state_s;

  gpm_state_s s;
  gpm_state_s next_s;

  // both selection registers as one field per line
  logic [gpm_pkg::SEL_A_W+gpm_pkg::SEL_B_W-1:0] sel_all;
  // one bit per line: line in primary function
  logic [6:0] prim;
  // filtered line levels
  logic [6:0] deb;
  // secondary output: line drives, value, drive enable
  logic [6:0] sec_drv;
  logic [6:0] sec_val;
  // edge events of this cycle
  logic [6:0] rise;
  logic [6:0] fall;
  logic [6:0] ev;
  // wake gating for lines that cannot wake from off
  logic [6:0] wake_block;

  assign sel_all = {pad_func_select_b, pad_func_select_a};

  // primary-mode decode per line
  always_comb begin
    for (int i = 0; i < gpm_pkg::NLINES; i++) begin
      prim[i] = (sel_all[i*gpm_pkg::SEL_W +: gpm_pkg::SEL_W] == gpm_pkg::SEL_PRIMARY);
    end
  end

  // debounce filter per line
  for (genvar g = 0; g < gpm_pkg::NLINES; g++) begin : g_deb
    gpm_debounce #(
      .CYCLES(gpm_pkg::DEB_CYCLES)
    ) u_deb (
      .clk_sys(clk_sys),
      .srst(srst),
      .level_in(s.stable[g]),
      // bypassed while the pipeline primes, so the filter starts from the real level
      .enable(pcfg.line_debounce_enable[g] & s.settle[4]),
      .level_out(deb[g])
    );
  end

  // secondary output functions per line
  always_comb begin
    // default: line not driven by any secondary output
    sec_drv = '0;
    sec_val = '0;
    // line 0: supply enable a
    if (sel_all[0 +: 3] == gpm_pkg::SEL_ALT3) begin
      sec_drv[0] = 1'b1;
      sec_val[0] = fout.ext_supply_en_a;
    end
    // line 2: dvs link data, direction set by the link
    if (sel_all[6 +: 3] == gpm_pkg::SEL_ALT2) begin
      sec_drv[2] = fout.dvs_data_oe;
      sec_val[2] = fout.dvs_data_out;
    end
    // line 3: supply enable a
    if (sel_all[9 +: 3] == gpm_pkg::SEL_ALT1) begin
      sec_drv[3] = 1'b1;
      sec_val[3] = fout.ext_supply_en_a;
    end
    // line 4: supply enable b, or dvs link clock / select
    if (sel_all[12 +: 3] == gpm_pkg::SEL_ALT1) begin
      sec_drv[4] = 1'b1;
      sec_val[4] = fout.ext_supply_en_b;
    end else if (sel_all[12 +: 3] == gpm_pkg::SEL_ALT2) begin
      sec_drv[4] = fout.dvs_clock_cs_oe;
      sec_val[4] = fout.dvs_clock_cs_out;
    end
    // line 5: supply enable c
    if (sel_all[15 +: 3] == gpm_pkg::SEL_ALT2) begin
      sec_drv[5] = 1'b1;
      sec_val[5] = fout.ext_supply_en_c;
    end
    // line 6: supplies valid, or supply enable c
    if (sel_all[18 +: 3] == gpm_pkg::SEL_ALT1) begin
      sec_drv[6] = 1'b1;
      sec_val[6] = fout.supplies_valid_out;
    end else if (sel_all[18 +: 3] == gpm_pkg::SEL_ALT2) begin
      sec_drv[6] = 1'b1;
      sec_val[6] = fout.ext_supply_en_c;
    end
  end

  // edge detection on filtered levels
  always_comb begin
    rise = deb & ~s.prev;
    fall = ~deb & s.prev;
    // only primary lines of an enabled port give events; none until prev
    // holds a real filtered level, else a pin idling high looks like a rise
    ev = ((rise & pcfg.rise_enable) | (fall & pcfg.fall_enable))
      & prim & {7{pcfg.enable & s.settle[5]}};
    // io-domain lines are no on request while off
    wake_block = off_state ? gpm_pkg::IO_DOMAIN_LINES : gpm_pkg::RST_LINES;
  end

  // next state
  always_comb begin
    next_s = s;

    // three-stage synchroniser, change taken when stages 2 and 3 agree
    next_s.sync1 = pad_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < gpm_pkg::NLINES; i++) begin
      // stages disagree while the pin moves: keep the old level
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.stable[i] = s.sync3[i];
      end
    end

    // remember filtered level for edge detection
    next_s.prev = deb;

    // count the pipeline in after reset, one stage per edge
    next_s.settle = {s.settle[4:0], 1'b1};

    // output data: full write, then clear, then set
    if (dwr.write_en) begin
      next_s.out_data = dwr.write_data;
    end
    if (dwr.clear_en) begin
      // zero bits leave their data untouched
      next_s.out_data = next_s.out_data & ~dwr.clear_bits;
    end
    // set applied last, so it wins over a clear of the same bit
    if (dwr.set_en) begin
      next_s.out_data = next_s.out_data | dwr.set_bits;
    end

    // sticky status: masked events are dropped, set beats clear
    // a clear and an event in one cycle leave the bit set
    next_s.status = (s.status & ~status_clear) | (ev & ~pcfg.irq_mask);
    next_s.irq = |next_s.status;

    // wake-up pulse from any enabled line event
    // io-domain lines stay blocked while the device is off
    next_s.wake = |(ev & pcfg.wake_enable & ~wake_block);

    // input data: level of primary input lines only
    next_s.data_in = deb & ~pcfg.line_direction & prim & {7{pcfg.enable}};

    // pad drive and pulls per line
    for (int i = 0; i < gpm_pkg::NLINES; i++) begin
      next_s.pad_out[i] = 1'b0;
      next_s.pad_oe[i] = 1'b0;
      next_s.pull_up[i] = 1'b0;
      next_s.pull_down[i] = 1'b0;
      if (prim[i]) begin
        // primary: only when the port is enabled
        if (pcfg.enable) begin
          if (pcfg.line_direction[i]) begin
            if (pcfg.line_open_drain_enable[i]) begin
              // open drain: pull low only, release for a one
              next_s.pad_oe[i] = ~next_s.out_data[i];
            end else begin
              next_s.pad_oe[i] = 1'b1;
              next_s.pad_out[i] = next_s.out_data[i];
            end
          end
          // pull-up wins when both pulls are asked for
          next_s.pull_up[i] = pcfg.line_pull_config_b[i];
          next_s.pull_down[i] = pcfg.line_pull_config_a[i] & ~pcfg.line_pull_config_b[i];
        end
      end else begin
        // secondary: primary settings have no effect here
        if (sec_drv[i]) begin
          if (scfg.open_drain[i]) begin
            next_s.pad_oe[i] = ~sec_val[i];
          end else begin
            next_s.pad_oe[i] = 1'b1;
            next_s.pad_out[i] = sec_val[i];
          end
        end
        next_s.pull_up[i] = scfg.pull_up[i];
        next_s.pull_down[i] = scfg.pull_down[i] & ~scfg.pull_up[i];
      end
    end

    // secondary input functions, idle when not selected
    next_s.fin = gpm_pkg::FIN_IDLE;
    // line 0
    case (sel_all[0 +: 3])
      gpm_pkg::SEL_ALT1: begin
        next_s.fin.power_down_in = s.stable[0];
      end
      gpm_pkg::SEL_ALT2: begin
        next_s.fin.periph_power_req_b = s.stable[0];
      end
      default: begin
        // primary or unused code: input stays idle
      end
    endcase
    // line 1
    case (sel_all[3 +: 3])
      gpm_pkg::SEL_ALT1: begin
        next_s.fin.reset_in = s.stable[1];
      end
      gpm_pkg::SEL_ALT2: begin
        next_s.fin.warm_reset_in_n = s.stable[1];
      end
      gpm_pkg::SEL_ALT3: begin
        next_s.fin.bus_supply_sense_in = s.stable[1];
      end
      gpm_pkg::SEL_ALT4: begin
        next_s.fin.periph_power_req_a = s.stable[1];
      end
      default: begin
      end
    endcase
    // line 2, request b shared with line 0
    case (sel_all[6 +: 3])
      gpm_pkg::SEL_ALT1: begin
        next_s.fin.periph_power_req_b = next_s.fin.periph_power_req_b | s.stable[2];
      end
      gpm_pkg::SEL_ALT2: begin
        next_s.fin.dvs_data_in = s.stable[2];
      end
      default: begin
      end
    endcase
    // line 3
    if (sel_all[9 +: 3] == gpm_pkg::SEL_ALT2) begin
      next_s.fin.converter_sync_in = s.stable[3];
    end
    // line 4
    if (sel_all[12 +: 3] == gpm_pkg::SEL_ALT2) begin
      next_s.fin.dvs_clock_cs_in = s.stable[4];
    end
    // line 5
    case (sel_all[15 +: 3])
      gpm_pkg::SEL_ALT1: begin
        next_s.fin.hold_on_in = s.stable[5];
      end
      gpm_pkg::SEL_ALT3: begin
        next_s.fin.sleep_req_in_n = s.stable[5];
      end
      default: begin
      end
    endcase
    // hold the idle levels until the synchroniser holds real pad levels,
    // so active-low inputs such as warm reset do not pulse after reset
    if (!s.settle[3]) begin
      next_s.fin = gpm_pkg::FIN_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // pads released, pulls off, pipeline marked unsettled
      s <= '0;
      s.fin <= gpm_pkg::FIN_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // all outputs straight from the state register
  assign pad_out = s.pad_out;
  assign pad_oe = s.pad_oe;
  assign pad_pull_up = s.pull_up;
  assign pad_pull_down = s.pull_down;
  assign fin = s.fin;
  assign data_in = s.data_in;
  assign out_data = s.out_data;
  assign edge_status = s.status;
  assign irq = s.irq;
  assign wake_req = s.wake;

endmodule

// File: gpm_port_asserts.sv
`timescale 1ns/1ps
module gpm_port_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  input wire logic [6:0] pad_pull_up,
  input wire logic [6:0] pad_pull_down,
  input wire logic [gpm_pkg::SEL_A_W-1:0] pad_func_select_a,
  input wire logic [gpm_pkg::SEL_B_W-1:0] pad_func_select_b,
  input wire gpm_pkg::gpm_pcfg_s pcfg,
  input wire gpm_pkg::gpm_scfg_s scfg,
  input wire gpm_pkg::gpm_dwr_s dwr,
  input wire logic [6:0] status_clear,
  input wire gpm_pkg::gpm_fout_s fout,
  input wire logic [6:0] out_data,
  input wire logic [6:0] edge_status,
  input wire logic irq
);
  logic [20:0] sel; // all function codes, line i at [3i+:3]
  logic [6:0] prim; // lines in primary function
  logic [6:0] pe; // enabled primary lines
  logic [6:0] pp; // push-pull primary outputs
  logic [6:0] po; // open-drain primary outputs
  logic [6:0] pu; // expected primary pull-ups
  logic [6:0] pd; // expected primary pull-downs
  logic [6:0] su; // expected secondary pull-ups
  logic [6:0] nxt; // output data due after this edge
  assign sel = {pad_func_select_b, pad_func_select_a};
  // decode which lines are primary
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      prim[i] = (sel[3*i+:3] == gpm_pkg::SEL_PRIMARY);
    end
  end
  assign pe = pcfg.enable ? prim : 7'h00;
  assign pp = pe & pcfg.line_direction & ~pcfg.line_open_drain_enable;
  assign po = pe & pcfg.line_direction & pcfg.line_open_drain_enable;
  assign pu = pcfg.line_pull_config_b & pe;
  assign pd = pcfg.line_pull_config_a & ~pcfg.line_pull_config_b & pe;
  assign su = scfg.pull_up & ~prim;
  // write first, then clear, then set
  assign nxt = ((dwr.write_en ? dwr.write_data : out_data) & ~(dwr.clear_en ? dwr.clear_bits : 7'h00))
    | (dwr.set_en ? dwr.set_bits : 7'h00);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_OUT_UPDATE: assert property (1'b1 |=> out_data == $past(nxt))
    else $error("output data not updated by strobes");
  AST_IRQ_LEVEL: assert property (irq == (edge_status != 7'h00))
    else $error("irq does not follow edge status");
  AST_CLEAR: assert property ((status_clear != 7'h00) && ((pcfg.rise_enable | pcfg.fall_enable) == 7'h00)
    |=> (edge_status & $past(status_clear)) == 7'h00)
    else $error("status bit survived its clear");
  AST_MASKED: assert property (1'b1 |=> (edge_status & ~$past(edge_status) & $past(pcfg.irq_mask)) == 7'h00)
    else $error("masked line recorded an edge");
  AST_SEC_QUIET: assert property (1'b1 |=> (edge_status & ~$past(edge_status) & ~$past(prim)) == 7'h00)
    else $error("secondary line recorded an edge");
  AST_OFF_QUIET: assert property (!pcfg.enable |=> ((pad_oe | pad_pull_up | pad_pull_down) & $past(prim)) == 7'h00)
    else $error("disabled primary line driven or pulled");
  AST_PP_DRIVE: assert property (1'b1 |=> (pad_oe & $past(pp)) == $past(pp) && (pad_out & $past(pp)) == (out_data & $past(pp)))
    else $error("push-pull output not driving data");
  AST_OD_DRIVE: assert property (1'b1 |=> (pad_out & $past(po)) == 7'h00 && (pad_oe & $past(po)) == (~out_data & $past(po)))
    else $error("open-drain output wrong");
  AST_PULLS: assert property (1'b1 |=> (pad_pull_up & $past(pe)) == $past(pu) && (pad_pull_down & $past(pe)) == $past(pd))
    else $error("primary pulls wrong");
  AST_SEC_PULL: assert property (1'b1 |=> (pad_pull_up & ~$past(prim)) == $past(su))
    else $error("secondary pull-up wrong");
  AST_SUPPLY_A: assert property (sel[11:9] == 3'h1 |=> pad_oe[3] && pad_out[3] == $past(fout.ext_supply_en_a))
    else $error("line 3 supply enable not driven");
  C_IRQ: cover property ($rose(irq));
  C_SETCLR: cover property (dwr.set_en && dwr.clear_en);
  C_SUPPLY: cover property (sel[11:9] == 3'h1);
endmodule

bind gpm_port gpm_port_asserts i_gpm_port_asserts (.clk_sys(clk_sys), .srst(srst), .pad_out(pad_out),
  .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
  .pad_func_select_a(pad_func_select_a), .pad_func_select_b(pad_func_select_b), .pcfg(pcfg), .scfg(scfg),
  .dwr(dwr), .status_clear(status_clear), .fout(fout), .out_data(out_data), .edge_status(edge_status),
  .irq(irq));

// File: gpm_pad_model.sv
`timescale 1ns/1ps
module gpm_pad_model (
  input wire logic clk_sys,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  input wire logic [6:0] pad_pull_up,
  input wire logic [6:0] pad_pull_down,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  output logic [6:0] pad_in
);
  logic [6:0] last = 7'h00; // wire level at the previous edge
  // remember the level so a floating wire can wander
  always @(posedge clk_sys) begin
    last <= pad_in;
  end
  // wire level: device drive, then far side, then pulls, else wandering
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last[i];
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0; // 40 MHz clock
  logic srst; // synchronous reset
  logic [20:0] sel; // function codes, line i at [3i+:3]
  gpm_pkg::gpm_pcfg_s pcfg;
  gpm_pkg::gpm_scfg_s scfg;
  gpm_pkg::gpm_dwr_s dwr;
  gpm_pkg::gpm_fout_s fout;
  gpm_pkg::gpm_fin_s fin;
  logic [6:0] status_clear, ext_en, ext_val, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [6:0] data_in, out_data, edge_status, exp_out;
  logic off_state, irq, wake_req;
  int compares = 0, miscompares = 0, wakes = 0, w0;
  always #12.5 clk_sys = ~clk_sys;
  gpm_port i_gpm_port (.clk_sys(clk_sys), .srst(srst), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_func_select_a(sel[11:0]),
    .pad_func_select_b(sel[20:12]), .pcfg(pcfg), .scfg(scfg), .dwr(dwr), .status_clear(status_clear),
    .off_state(off_state), .fout(fout), .fin(fin), .data_in(data_in), .out_data(out_data),
    .edge_status(edge_status), .irq(irq), .wake_req(wake_req));
  gpm_pad_model i_gpm_pad_model (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  // count wake pulses
  always @(posedge clk_sys) begin
    if (wake_req === 1'b1) wakes++;
  end
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (exp !== got) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one strobe cycle of write, set and clear, then check the data
  task automatic dw(input logic we, input logic [6:0] wd, input logic [6:0] sb, input logic [6:0] cb);
    dwr = '{write_en: we, write_data: wd, set_en: 1'b1, set_bits: sb, clear_en: 1'b1, clear_bits: cb};
    exp_out = ((we ? wd : exp_out) & ~cb) | sb;
    tick(1);
    dwr = '0;
    tick(1);
    chk("out_data", exp_out, out_data);
  endtask
  // wait a bounded time for the interrupt
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("irq", 1'b1, irq);
    if (irq !== 1'b1) wrap_up();
  endtask
  // stop edge detection, let it drain, clear all status
  task automatic clr();
    pcfg.rise_enable = 7'h00;
    pcfg.fall_enable = 7'h00;
    tick(8);
    status_clear = 7'h7F;
    tick(1);
    status_clear = 7'h00;
    tick(1);
    chk("edge_status", 7'h00, edge_status);
  endtask
  // select one secondary function, drive it and check the result
  task automatic sec(input int ln, input logic [2:0] code, input logic [7:0] fv, input int fb);
    logic [10:0] exp;
    exp = gpm_pkg::FIN_IDLE;
    exp[fb] = ~exp[fb];
    sel = '0;
    sel[3*ln+:3] = code;
    fout = fv;
    ext_en = (fv == 8'h00) ? (7'h01 << ln) : 7'h00;
    ext_val = {7{exp[fb]}};
    tick(8);
    if (fv != 8'h00) chk("sec_drive", 2'b11, {pad_out[ln], pad_oe[ln]});
    else chk("fin", exp, fin);
  endtask
  initial begin
    sel = '0;
    pcfg = '0;
    scfg = '0;
    dwr = '0;
    fout = '0;
    status_clear = 7'h00;
    off_state = 1'b0;
    ext_en = 7'h00;
    ext_val = 7'h00;
    exp_out = 7'h00;
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    pcfg.line_direction = 7'h7F;
    tick(2);
    chk("fin", gpm_pkg::FIN_IDLE, fin);
    chk("pad_oe", 7'h00, pad_oe);
    $display("test reset done");
    dw(1'b1, 7'h55, 7'h00, 7'h00);
    pcfg.enable = 1'b1;
    tick(2);
    chk("pad_out", 7'h55, pad_out);
    chk("pad_oe", 7'h7F, pad_oe);
    dw(1'b0, 7'h00, 7'h0A, 7'h03);
    dw(1'b0, 7'h00, 7'h00, 7'h00);
    dw(1'b0, 7'h00, 7'h00, 7'h40);
    pcfg.line_open_drain_enable = 7'h01;
    pcfg.line_pull_config_b = 7'h01;
    pcfg.line_pull_config_a = 7'h02;
    tick(2);
    chk("od_low", 2'b01, {pad_out[0], pad_oe[0]});
    dw(1'b0, 7'h00, 7'h01, 7'h00);
    chk("od_high", 3'b001, {pad_oe[0], pad_pull_down[0], pad_in[0]});
    chk("pull_down", 1'b1, pad_pull_down[1]);
    $display("test output done");
    pcfg = '{enable: 1'b1, wake_enable: 7'h7F, default: 7'h00};
    ext_en = 7'h7F;
    clr();
    pcfg.rise_enable = 7'h08;
    pcfg.fall_enable = 7'h20;
    w0 = wakes;
    ext_val[3] = 1'b1;
    wait_irq();
    chk("edge_status", 7'h08, edge_status);
    chk("data_in", 7'h08, data_in & 7'h08);
    tick(2);
    chk("wakes", 1, wakes - w0);
    ext_val[5] = 1'b1;
    tick(10);
    chk("rise_ignored", 7'h08, edge_status);
    ext_val[5] = 1'b0;
    tick(10);
    chk("fall_seen", 7'h28, edge_status);
    clr();
    pcfg.irq_mask = 7'h08;
    pcfg.rise_enable = 7'h08;
    ext_val[3] = 1'b0;
    tick(10);
    ext_val[3] = 1'b1;
    tick(10);
    chk("masked", 7'h00, edge_status);
    pcfg.irq_mask = 7'h00;
    sel[11:9] = 3'h2;
    ext_val[3] = 1'b0;
    tick(10);
    ext_val[3] = 1'b1;
    tick(10);
    chk("secondary", 7'h00, edge_status);
    sel = '0;
    off_state = 1'b1;
    tick(10);
    pcfg.rise_enable = 7'h15;
    w0 = wakes;
    ext_val[2] = 1'b1;
    wait_irq();
    tick(2);
    chk("off_wake_io", 0, wakes - w0);
    ext_val[0] = 1'b1;
    tick(10);
    chk("off_wake_line0", 1, wakes - w0);
    off_state = 1'b0;
    clr();
    pcfg.rise_enable = 7'h40;
    pcfg.fall_enable = 7'h40;
    ext_val[6] = 1'b1;
    wait_irq();
    status_clear = 7'h40;
    tick(1);
    status_clear = 7'h00;
    ext_val[6] = 1'b0;
    wait_irq();
    chk("both_edges", 7'h40, edge_status);
    clr();
    $display("test events done");
    pcfg.line_debounce_enable = 7'h02;
    pcfg.rise_enable = 7'h02;
    ext_val[1] = 1'b1;
    tick(10);
    ext_val[1] = 1'b0;
    tick(20);
    ext_val[1] = 1'b1;
    tick(gpm_pkg::DEB_CYCLES - 100);
    chk("debounce_early", 7'h00, edge_status);
    tick(200);
    chk("debounce_late", 7'h02, edge_status);
    clr();
    $display("test debounce done");
    sec(0, 3'h1, 8'h00, 10);
    sec(0, 3'h2, 8'h00, 8);
    sec(0, 3'h3, 8'h80, 0);
    sec(1, 3'h1, 8'h00, 7);
    sec(1, 3'h2, 8'h00, 6);
    sec(1, 3'h3, 8'h00, 5);
    sec(1, 3'h4, 8'h00, 9);
    sec(2, 3'h1, 8'h00, 8);
    sec(2, 3'h2, 8'h00, 1);
    sec(2, 3'h2, 8'h0C, 0);
    sec(3, 3'h1, 8'h80, 0);
    sec(3, 3'h2, 8'h00, 4);
    sec(4, 3'h1, 8'h40, 0);
    sec(4, 3'h2, 8'h00, 0);
    sec(4, 3'h2, 8'h03, 0);
    sec(5, 3'h1, 8'h00, 3);
    sec(5, 3'h2, 8'h20, 0);
    sec(5, 3'h3, 8'h00, 2);
    sec(6, 3'h1, 8'h10, 0);
    sec(6, 3'h2, 8'h20, 0);
    sel = '0;
    sel[17:15] = 3'h1;
    ext_en = 7'h00;
    scfg.pull_up = 7'h20;
    pcfg.line_pull_config_a = 7'h7F;
    tick(2);
    chk("sec_pulls", 2'b10, {pad_pull_up[5], pad_pull_down[5]});
    sel[17:15] = 3'h2;
    scfg = '{pull_up: 7'h00, pull_down: 7'h20, open_drain: 7'h20};
    fout = '0;
    tick(2);
    chk("sec_od_low", 4'h5, {pad_out[5], pad_oe[5], pad_pull_up[5], pad_pull_down[5]});
    fout.ext_supply_en_c = 1'b1;
    tick(2);
    chk("sec_od_high", 1'b0, pad_oe[5]);
    $display("test secondary done");
    wrap_up();
  end
endmodule
